// ---- design/etp_consts.svh ----
// Constants for the E1 transmit port and master clock block
`ifndef ETP_CONSTS_SVH
`define ETP_CONSTS_SVH
`define ETP_CLK_PERIOD_NS 50
`define ETP_LOSS_TIME_NS 10000
`define ETP_LOSS_CYCLES ((`ETP_LOSS_TIME_NS + `ETP_CLK_PERIOD_NS - 1) / `ETP_CLK_PERIOD_NS)
`define ETP_DUTY_MIN_PCT 30
`define ETP_PCT_SCALE 100
`define ETP_ADDR_CFG1 4'h0
`define ETP_ADDR_MODE 4'h1
`define ETP_ADDR_STAT 4'h2
`define ETP_ADDR_ISTS 4'h3
`define ETP_ADDR_IMSK 4'h4
`define ETP_SEL_HI 7
`define ETP_SEL_LO 5
`define ETP_EDGE_BIT 4
`define ETP_INV_BIT 3
`define ETP_CFG1_RST 8'h00
`define ETP_MASK_RST 4'h0
`define ETP_STRAP_BASE 4'h8
`define ETP_STRAP_MAX 4'hb
`define ETP_STRAP_SETTLE 2'h3
`define ETP_INT_LOST 0
`define ETP_INT_RECOV 1
`define ETP_INT_STRAP 2
`define ETP_INT_RAIL 3
`define ETP_SYNC_W 8
`endif

// ---- design/etp_pkg.sv ----
// Types for the E1 transmit port and master clock block
package etp_pkg;
    typedef enum logic [1:0] {
        ETP_MODE_SINGLE_NRZ = 2'b00,
        ETP_MODE_DUAL_NRZ = 2'b01,
        ETP_MODE_DUAL_RZ = 2'b10
    } etp_mode_t;
    typedef enum logic [2:0] {
        ETP_IND_PATTERN = 3'b000,
        ETP_IND_AIS = 3'b001,
        ETP_IND_OVERCURRENT = 3'b010,
        ETP_IND_TX_LOS = 3'b011,
        ETP_IND_EXZ = 3'b100,
        ETP_IND_BPV = 3'b101,
        ETP_IND_EXZ_BPV = 3'b110,
        ETP_IND_SYS_LOS = 3'b111
    } etp_ind_sel_t;
    typedef enum logic [0:0] {
        ETP_MON_RUN = 1'b0,
        ETP_MON_LOST = 1'b1
    } etp_mon_state_t;
endpackage : etp_pkg

// ---- design/etp_mon_if.sv ----
// Master clock monitor status carried to the top
`timescale 1ns/1ps
interface etp_mon_if;
    logic lost;
    logic recovered;
    modport mon (output lost, output recovered);
    modport top (input lost, input recovered);
endinterface : etp_mon_if

// ---- design/etp_sync.sv ----
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module etp_sync #(
    parameter int W = 1
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            // Per-bit flops keep one process per variable
            logic s1_q, s1_d, s2_q, s2_d;
            always_comb begin
                s1_d = ce ? din[i] : s1_q;
                s2_d = ce ? s1_q : s2_q;
            end
            always_ff @(posedge clk_sys) begin
                if (!nrst) begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                end else begin
                    s1_q <= s1_d;
                    s2_q <= s2_d;
                end
            end
            assign dout[i] = s2_q;
        end
    endgenerate
endmodule : etp_sync

// ---- design/etp_mclk_mon.sv ----
// Master clock duty monitor: loss and recovery per window
`timescale 1ns/1ps
`include "etp_consts.svh"
module etp_mclk_mon
    import etp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic ce,
    input wire logic mclk_s,
    etp_mon_if.mon mon
);
    localparam logic [7:0] WIN_LAST = 8'(`ETP_LOSS_CYCLES - 1);
    localparam logic [15:0] DUTY_LIM = 16'(`ETP_DUTY_MIN_PCT * `ETP_LOSS_CYCLES);
    etp_mon_state_t state_q, state_d;
    logic [7:0] win_q, win_d, hi_q, hi_d, hi_tot;
    logic rec_q, rec_d, low_duty;
    always_comb begin
        hi_tot = hi_q + {7'h00, mclk_s};
        low_duty = (16'(hi_tot) * 16'(`ETP_PCT_SCALE)) < DUTY_LIM;
        state_d = state_q;
        win_d = win_q;
        hi_d = hi_q;
        rec_d = 1'b0;
        if (ce) begin
            win_d = (win_q == WIN_LAST) ? 8'h00 : win_q + 8'h01;
            hi_d = (win_q == WIN_LAST) ? 8'h00 : hi_tot;
            if (win_q == WIN_LAST) begin
                case (state_q)
                    ETP_MON_RUN: begin
                        if (low_duty) state_d = ETP_MON_LOST;
                    end
                    ETP_MON_LOST: begin
                        if (!low_duty) begin
                            state_d = ETP_MON_RUN;
                            rec_d = 1'b1;
                        end
                    end
                    default: state_d = ETP_MON_RUN;
                endcase
            end
        end else begin
            rec_d = rec_q;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            state_q <= ETP_MON_RUN;
            win_q <= 8'h00;
            hi_q <= 8'h00;
            rec_q <= 1'b0;
        end else begin
            state_q <= state_d;
            win_q <= win_d;
            hi_q <= hi_d;
            rec_q <= rec_d;
        end
    end
    assign mon.lost = (state_q == ETP_MON_LOST);
    assign mon.recovered = rec_q;
endmodule : etp_mclk_mon

// ---- design/etp_tx_port.sv ----
// E1 transmit system port pin logic with master clock supervision
// Overview of operation
// - Single rail NRZ and dual rail RZ turn the shared negative/indication pin into the indication output.
// - Bits 7 to 5 of tx_config_one pick which alarm the indication output shows.
// - The indication output changes on the active transmit clock edge when that clock exists.
// - The indication output is active high whatever the data polarity setting.
// - In both NRZ modes the clock/negative pin is the transmit clock input.
// - Transmit data is sampled on the active clock edge and the system holds it valid there.
// - Bit 4 of tx_config_one picks the active clock edge for sampling and indication.
// - In dual rail RZ no clock is used and the clock pin carries the negative rail.
// - A master clock under 30% duty for 10 us is lost, and its recovery resets the block.
// - The master clock strap codes 1000 to 1011 give one to four times 2.048 MHz.
// - Bit 3 of tx_config_one sets the active level of the data inputs.
// - A rail pair gives a positive mark, a negative mark, or a space when both are equal.
//
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "etp_consts.svh"
module etp_tx_port
    import etp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic tx_positive_rail_in,
    input wire logic tx_line_clock_in,
    input wire logic tx_negative_rail_in,
    output logic tx_multiplex_indication_out,
    output logic tx_multiplex_indication_oe_n,
    input wire logic master_clock_in,
    input wire logic [3:0] master_clock_freq_strap,
    input wire logic arbitrary_pattern_status,
    input wire logic system_ais_sent,
    input wire logic tx_overcurrent,
    input wire logic tx_loss_of_signal,
    input wire logic system_excess_zeros,
    input wire logic system_bipolar_violation,
    input wire logic system_loss_of_signal,
    output logic line_pos_mark,
    output logic line_neg_mark,
    output logic line_bit_strobe,
    output logic self_reset_pulse,
    output logic irq
);
    logic [`ETP_SYNC_W-1:0] pins_s;
    logic pos_s, clk_s, neg_s, mclk_s;
    logic [3:0] strap_s;
    etp_mon_if mon_bus ();

    etp_sync #(.W(`ETP_SYNC_W)) u_sync (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .ce(ce),
        .din({master_clock_freq_strap, master_clock_in, tx_negative_rail_in,
              tx_line_clock_in, tx_positive_rail_in}),
        .dout(pins_s)
    );
    assign pos_s = pins_s[0];
    assign clk_s = pins_s[1];
    assign neg_s = pins_s[2];
    assign mclk_s = pins_s[3];
    assign strap_s = pins_s[7:4];

    etp_mclk_mon u_mon (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .ce(ce),
        .mclk_s(mclk_s),
        .mon(mon_bus.mon)
    );

    // Register state
    logic [7:0] cfg_q, cfg_d;
    etp_mode_t mode_q, mode_d;
    logic [3:0] mask_q, mask_d, ists_q, ists_d;
    logic [7:0] rdata_q, rdata_d;
    logic [3:0] strap_q, strap_d;
    logic strap_ok_q, strap_ok_d;
    logic [1:0] settle_q, settle_d;
    logic lost_prev_q, lost_prev_d;
    logic soft_rst, strap_cap;
    logic [3:0] events;

    // Datapath state
    logic clk_prev_q, clk_prev_d, rz_prev_q, rz_prev_d;
    logic ind_q, ind_d, oe_n_q, oe_n_d;
    logic pos_q, pos_d, neg_q, neg_d, stb_q, stb_d;
    logic srst_q, srst_d, irq_q, irq_d;

    // Decoded controls
    etp_ind_sel_t sel;
    logic edge_sel, inv, act_edge, drive, sel_val;
    logic pos_lvl, neg_lvl, rail_both;

    assign sel = etp_ind_sel_t'(cfg_q[`ETP_SEL_HI:`ETP_SEL_LO]);
    assign edge_sel = cfg_q[`ETP_EDGE_BIT];
    assign inv = cfg_q[`ETP_INV_BIT];
    assign soft_rst = mon_bus.recovered;

    always_comb begin
        // Falling edge when the select bit is set, rising otherwise
        act_edge = edge_sel ? (~clk_s & clk_prev_q) : (clk_s & ~clk_prev_q);
        drive = (mode_q != ETP_MODE_DUAL_NRZ);
        // Data levels follow the polarity bit, the indication does not
        pos_lvl = pos_s ^ inv;
        // RZ takes its negative rail from the clock pin
        neg_lvl = ((mode_q == ETP_MODE_DUAL_RZ) ? clk_s : neg_s) ^ inv;
        rail_both = pos_lvl & neg_lvl;
        case (sel)
            ETP_IND_PATTERN: sel_val = arbitrary_pattern_status;
            ETP_IND_AIS: sel_val = system_ais_sent;
            ETP_IND_OVERCURRENT: sel_val = tx_overcurrent;
            ETP_IND_TX_LOS: sel_val = tx_loss_of_signal;
            ETP_IND_EXZ: sel_val = system_excess_zeros;
            ETP_IND_BPV: sel_val = system_bipolar_violation;
            ETP_IND_EXZ_BPV: sel_val = system_excess_zeros | system_bipolar_violation;
            ETP_IND_SYS_LOS: sel_val = system_loss_of_signal;
            default: sel_val = 1'b0;
        endcase
    end

    // Pin datapath
    always_comb begin
        clk_prev_d = clk_prev_q;
        rz_prev_d = rz_prev_q;
        ind_d = ind_q;
        oe_n_d = oe_n_q;
        pos_d = pos_q;
        neg_d = neg_q;
        stb_d = stb_q;
        if (ce) begin
            clk_prev_d = clk_s;
            rz_prev_d = pos_lvl | neg_lvl;
            stb_d = 1'b0;
            oe_n_d = ~drive;
            if (!drive) begin
                ind_d = 1'b0;
            end else if (mode_q == ETP_MODE_DUAL_RZ || act_edge) begin
                ind_d = sel_val;
            end
            case (mode_q)
                ETP_MODE_SINGLE_NRZ: begin
                    if (act_edge) begin
                        pos_d = pos_lvl;
                        neg_d = 1'b0;
                        stb_d = 1'b1;
                    end
                end
                ETP_MODE_DUAL_NRZ: begin
                    if (act_edge) begin
                        pos_d = pos_lvl & ~neg_lvl;
                        neg_d = neg_lvl & ~pos_lvl;
                        stb_d = 1'b1;
                    end
                end
                ETP_MODE_DUAL_RZ: begin
                    if ((pos_lvl | neg_lvl) && !rz_prev_q) begin
                        pos_d = pos_lvl & ~neg_lvl;
                        neg_d = neg_lvl & ~pos_lvl;
                        stb_d = 1'b1;
                    end
                end
                default: begin
                    stb_d = 1'b0;
                end
            endcase
            if (soft_rst) begin
                ind_d = 1'b0;
                pos_d = 1'b0;
                neg_d = 1'b0;
                stb_d = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            clk_prev_q <= 1'b0;
            rz_prev_q <= 1'b0;
            ind_q <= 1'b0;
            oe_n_q <= 1'b0;
            pos_q <= 1'b0;
            neg_q <= 1'b0;
            stb_q <= 1'b0;
        end else begin
            clk_prev_q <= clk_prev_d;
            rz_prev_q <= rz_prev_d;
            ind_q <= ind_d;
            oe_n_q <= oe_n_d;
            pos_q <= pos_d;
            neg_q <= neg_d;
            stb_q <= stb_d;
        end
    end

    // Registers, straps and interrupts
    always_comb begin
        cfg_d = cfg_q;
        mode_d = mode_q;
        mask_d = mask_q;
        ists_d = ists_q;
        rdata_d = rdata_q;
        strap_d = strap_q;
        strap_ok_d = strap_ok_q;
        settle_d = settle_q;
        lost_prev_d = lost_prev_q;
        srst_d = srst_q;
        irq_d = irq_q;
        strap_cap = 1'b0;
        events = 4'h0;
        if (ce) begin
            lost_prev_d = mon_bus.lost;
            events[`ETP_INT_LOST] = mon_bus.lost & ~lost_prev_q;
            events[`ETP_INT_RECOV] = soft_rst;
            events[`ETP_INT_RAIL] = stb_d & rail_both & (mode_q != ETP_MODE_SINGLE_NRZ);
            // Straps are read once the synchroniser has filled
            if (settle_q != `ETP_STRAP_SETTLE) begin
                settle_d = settle_q + 2'h1;
            end
            strap_cap = (settle_q == `ETP_STRAP_SETTLE - 2'h1);
            if (strap_cap) begin
                strap_d = strap_s;
                strap_ok_d = (strap_s >= `ETP_STRAP_BASE) && (strap_s <= `ETP_STRAP_MAX);
                events[`ETP_INT_STRAP] = ~strap_ok_d;
            end
            rdata_d = 8'h00;
            if (reg_rd) begin
                case (reg_addr)
                    `ETP_ADDR_CFG1: rdata_d = cfg_q;
                    `ETP_ADDR_MODE: rdata_d = {6'h00, mode_q};
                    // Lost, strap valid, multiplier minus one, raw code
                    `ETP_ADDR_STAT: rdata_d = {mon_bus.lost, strap_ok_q, strap_q[1:0], strap_q};
                    `ETP_ADDR_ISTS: rdata_d = {4'h0, ists_q};
                    `ETP_ADDR_IMSK: rdata_d = {4'h0, mask_q};
                    default: rdata_d = 8'h00;
                endcase
            end
            if (reg_wr) begin
                case (reg_addr)
                    `ETP_ADDR_CFG1: cfg_d = reg_wdata;
                    `ETP_ADDR_MODE: begin
                        if (reg_wdata[1:0] != 2'b11) mode_d = etp_mode_t'(reg_wdata[1:0]);
                    end
                    `ETP_ADDR_ISTS: ists_d = ists_q & ~reg_wdata[3:0];
                    `ETP_ADDR_IMSK: mask_d = reg_wdata[3:0];
                    default: cfg_d = cfg_q;
                endcase
            end
            // A new event wins over a clear in the same cycle
            ists_d = ists_d | events;
            srst_d = soft_rst;
            if (soft_rst) begin
                cfg_d = `ETP_CFG1_RST;
                mode_d = ETP_MODE_SINGLE_NRZ;
                mask_d = `ETP_MASK_RST;
                settle_d = 2'h0;
            end
            irq_d = |(ists_d & mask_d);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            cfg_q <= `ETP_CFG1_RST;
            mode_q <= ETP_MODE_SINGLE_NRZ;
            mask_q <= `ETP_MASK_RST;
            ists_q <= 4'h0;
            rdata_q <= 8'h00;
            strap_q <= 4'h0;
            strap_ok_q <= 1'b0;
            settle_q <= 2'h0;
            lost_prev_q <= 1'b0;
            srst_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            cfg_q <= cfg_d;
            mode_q <= mode_d;
            mask_q <= mask_d;
            ists_q <= ists_d;
            rdata_q <= rdata_d;
            strap_q <= strap_d;
            strap_ok_q <= strap_ok_d;
            settle_q <= settle_d;
            lost_prev_q <= lost_prev_d;
            srst_q <= srst_d;
            irq_q <= irq_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign tx_multiplex_indication_out = ind_q;
    assign tx_multiplex_indication_oe_n = oe_n_q;
    assign line_pos_mark = pos_q;
    assign line_neg_mark = neg_q;
    assign line_bit_strobe = stb_q;
    assign self_reset_pulse = srst_q;
    assign irq = irq_q;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    sequence s_clock_back;
        ce && mon_bus.recovered;
    endsequence
    sequence s_reset_done;
        self_reset_pulse && cfg_q == `ETP_CFG1_RST && mode_q == ETP_MODE_SINGLE_NRZ;
    endsequence

    a_pin_drive_mode: assert property (ce |=>
        tx_multiplex_indication_oe_n == ($past(mode_q) == ETP_MODE_DUAL_NRZ))
        else $error("shared pin drive does not follow mode");
    a_ind_rz_select: assert property (ce && mode_q == ETP_MODE_DUAL_RZ && !soft_rst
        |=> tx_multiplex_indication_out == $past(sel_val))
        else $error("indication does not show selected source");
    a_ind_edge_update: assert property (ce && mode_q == ETP_MODE_SINGLE_NRZ && !act_edge
        && !soft_rst |=> $stable(tx_multiplex_indication_out))
        else $error("indication changed away from active edge");
    a_ind_act_high: assert property (ce && mode_q == ETP_MODE_DUAL_RZ && !soft_rst
        && sel == ETP_IND_SYS_LOS |=> tx_multiplex_indication_out == $past(system_loss_of_signal))
        else $error("indication not active high");
    a_nrz_sample: assert property (ce && mode_q != ETP_MODE_DUAL_RZ && !soft_rst
        |=> line_bit_strobe == $past(act_edge))
        else $error("sample not tied to transmit clock edge");
    a_edge_select: assert property (ce && mode_q == ETP_MODE_SINGLE_NRZ && edge_sel
        && clk_s && !clk_prev_q |=> !line_bit_strobe)
        else $error("sampled on the wrong clock edge");
    a_single_polarity: assert property (ce && mode_q == ETP_MODE_SINGLE_NRZ && act_edge
        && !soft_rst |=> line_pos_mark == ($past(pos_s) ^ $past(inv)) && !line_neg_mark)
        else $error("single rail data polarity wrong");
    a_rail_space: assert property (ce && mode_q == ETP_MODE_DUAL_NRZ && act_edge
        && pos_lvl == neg_lvl && !soft_rst |=> !line_pos_mark && !line_neg_mark)
        else $error("equal rails did not give a space");
    a_rz_neg_rail: assert property (ce && mode_q == ETP_MODE_DUAL_RZ && !pos_lvl
        && neg_lvl && !rz_prev_q && !soft_rst |=> line_bit_strobe && line_neg_mark)
        else $error("clock pin not used as negative rail");
    a_auto_reset: assert property (s_clock_back |=> s_reset_done)
        else $error("no self reset after master clock recovery");
    a_strap_catch: assert property (ce && strap_cap |=> strap_q == $past(strap_s)
        ##0 strap_ok_q == (strap_q[3:2] == 2'b10))
        else $error("strap code not captured");
    a_ind_dual_nrz: assert property (ce && mode_q == ETP_MODE_DUAL_NRZ
        |=> !tx_multiplex_indication_out)
        else $error("indication active in dual rail NRZ");
endmodule : etp_tx_port

// ---- test/etp_far_model.sv ----
// Far-side framer model driving the transmit pins
`timescale 1ns/1ps
module etp_far_model (
    input wire logic run,
    input wire logic dual,
    input wire logic rz,
    input wire logic inv,
    input wire logic edge_fall,
    output logic tclk_pin,
    output logic p_pin,
    output logic n_pin,
    output logic bit_p,
    output logic bit_n
);
    logic [31:0] seed_q;
    initial begin
        seed_q = 32'h1234_5678;
        {tclk_pin, p_pin, n_pin, bit_p, bit_n} = 5'h00;
        forever begin
            if (!run) begin
                // Clock stands still between frames, data lines wander outside RZ and rest low in RZ
                tclk_pin = 1'b0;
                p_pin = rz ? 1'b0 : ~p_pin;
                n_pin = rz ? 1'b0 : ~n_pin;
                #50;
            end else begin
                seed_q = {seed_q[30:0], seed_q[31] ^ seed_q[21] ^ seed_q[1] ^ seed_q[0]};
                bit_p = seed_q[0];
                bit_n = (dual || rz) && seed_q[1] && !(rz && seed_q[0]);
                if (rz) begin
                    {p_pin, n_pin} = {bit_p, bit_n};
                    #200 {p_pin, n_pin} = 2'b00;
                    #200;
                end else begin
                    // Data moves on the inactive edge only
                    tclk_pin = edge_fall;
                    {p_pin, n_pin} = {bit_p ^ inv, bit_n ^ inv};
                    #200 tclk_pin = ~edge_fall;
                    #200;
                end
            end
        end
    end
endmodule : etp_far_model

// ---- test/testbench.sv ----
// Self-checking testbench for the E1 transmit port
`timescale 1ns/1ps
`include "etp_consts.svh"
module testbench;
    import etp_pkg::*;
    logic clk_sys, nrst, reg_wr, reg_rd, master_clock_in;
    logic [3:0] reg_addr, strap, s;
    logic [7:0] reg_wdata, reg_rdata, rd_v;
    logic [6:0] src;
    logic [2:0] sel;
    logic ind, ind_oe_n, pos_m, neg_m, strobe, self_rst, irq;
    logic run, dual, rz, inv, efall, tclk_pin, p_pin, n_pin, bit_p, bit_n;
    logic [31:0] rnd;
    int fails = 0, checks = 0, strobes = 0, cycles = 0, mc_hi = 200, self_cnt = 0, k;
    etp_tx_port i_etp_tx_port (
        .clk_sys(clk_sys), .nrst(nrst), .ce(1'b1),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .tx_positive_rail_in(p_pin),
        .tx_line_clock_in(rz ? n_pin : tclk_pin),
        .tx_negative_rail_in(ind_oe_n ? n_pin : ind),
        .tx_multiplex_indication_out(ind), .tx_multiplex_indication_oe_n(ind_oe_n),
        .master_clock_in(master_clock_in), .master_clock_freq_strap(strap),
        .arbitrary_pattern_status(src[0]), .system_ais_sent(src[1]),
        .tx_overcurrent(src[2]), .tx_loss_of_signal(src[3]), .system_excess_zeros(src[4]),
        .system_bipolar_violation(src[5]), .system_loss_of_signal(src[6]),
        .line_pos_mark(pos_m), .line_neg_mark(neg_m), .line_bit_strobe(strobe),
        .self_reset_pulse(self_rst), .irq(irq)
    );
    etp_far_model i_etp_far_model (
        .run(run), .dual(dual), .rz(rz), .inv(inv), .edge_fall(efall),
        .tclk_pin(tclk_pin), .p_pin(p_pin), .n_pin(n_pin), .bit_p(bit_p), .bit_n(bit_n)
    );
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    initial begin
        master_clock_in = 1'b0;
        #3;
        forever begin
            master_clock_in = (mc_hi != 0);
            #(mc_hi) master_clock_in = 1'b0;
            #(400 - mc_hi);
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr
    function automatic logic ind_exp(input logic [2:0] f, input logic [6:0] v);
        return (f == 3'd6) ? (v[4] | v[5]) : (f == 3'd7) ? v[6] : v[f];
    endfunction : ind_exp
    task automatic wrap_up;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : wrap_up
    task automatic chk8(input string what, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s: expected %h, seen %h", what, e, g);
        end
    endtask : chk8
    task automatic chk1(input string what, input logic e, input logic g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s: expected %b, seen %b", what, e, g);
        end
    endtask : chk1
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 rd_v = reg_rdata;
    endtask : rd
    task automatic do_reset(input logic [3:0] code);
        @(posedge clk_sys);
        strap <= code;
        nrst <= 1'b0;
        repeat (5) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (5) @(posedge clk_sys);
    endtask : do_reset
    task automatic run_bits(input int n);
        @(posedge clk_sys);
        run <= 1'b1;
        repeat (n * 8) @(posedge clk_sys);
        run <= 1'b0;
        repeat (20) @(posedge clk_sys);
    endtask : run_bits
    always @(posedge clk_sys) begin
        cycles++;
        if (self_rst) self_cnt++;
        if (nrst && strobe) begin
            strobes++;
            chk1("pos mark", dual ? bit_p & ~bit_n : bit_p, pos_m);
            chk1("neg mark", bit_n & ~bit_p, neg_m);
            if (!dual) chk1("indication", ind_exp(sel, src), ind);
        end
        if (cycles == 12000) begin
            fails++;
            wrap_up();
        end
    end
    initial begin
        {nrst, reg_wr, reg_rd, run, dual, rz, inv, efall} = 8'h00;
        {reg_addr, reg_wdata, strap, src, sel} = 26'h000_0008;
        rnd = 32'hd1bb_20ed;
        // Each strap code is captured after a reset, plus one invalid code
        for (int i = 0; i < 5; i++) begin
            s = (i == 4) ? 4'h3 : 4'h8 + i[3:0];
            do_reset(s);
            rd(`ETP_ADDR_STAT);
            chk8("status", {1'b0, i < 4, s[1:0], s}, rd_v);
        end
        chk1("oe_n after reset", 1'b0, ind_oe_n);
        rd(`ETP_ADDR_CFG1);
        chk8("cfg reset", `ETP_CFG1_RST, rd_v);
        rd(4'hf);
        chk8("unmapped", 8'h00, rd_v);
        rd(`ETP_ADDR_ISTS);
        chk8("bad strap event", 8'h04, rd_v);
        chk1("irq masked", 1'b0, irq);
        wr(`ETP_ADDR_IMSK, 8'h04);
        repeat (2) @(posedge clk_sys);
        chk1("irq raised", 1'b1, irq);
        wr(`ETP_ADDR_ISTS, 8'h04);
        repeat (2) @(posedge clk_sys);
        chk1("irq cleared", 1'b0, irq);
        do_reset(4'h9);
        // Single rail: every indication source, both edges, both polarities
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            src <= rnd[6:0];
            sel = i[2:0];
            efall = i[0];
            inv = i[1];
            wr(`ETP_ADDR_CFG1, {sel, efall, inv, 3'b000});
            run_bits(12);
        end
        chk8("strobes seen", 8'h60, 8'(strobes));
        inv = 1'b0;
        wr(`ETP_ADDR_CFG1, {sel, 5'h00});
        wr(`ETP_ADDR_MODE, 8'h01);
        dual = 1'b1;
        repeat (2) @(posedge clk_sys);
        chk1("oe_n dual nrz", 1'b1, ind_oe_n);
        chk1("ind dual nrz", 1'b0, ind);
        wr(`ETP_ADDR_IMSK, 8'h08);
        run_bits(40);
        rd(`ETP_ADDR_ISTS);
        chk8("both rails event", 8'h08, rd_v);
        chk1("irq rails", 1'b1, irq);
        wr(`ETP_ADDR_ISTS, 8'h08);
        // Quiet the rails before the clock pin becomes the negative rail
        rz <= 1'b1;
        wr(`ETP_ADDR_MODE, 8'h02);
        repeat (2) @(posedge clk_sys);
        chk1("oe_n dual rz", 1'b0, ind_oe_n);
        wr(`ETP_ADDR_MODE, 8'h03);
        rd(`ETP_ADDR_MODE);
        chk8("mode kept", 8'h02, rd_v);
        run_bits(24);
        rnd = lfsr(rnd);
        src <= ~src;
        repeat (3) @(posedge clk_sys);
        chk1("ind dual rz", ind_exp(sel, src), ind);
        // Master clock loss, still lost at 25 percent duty, then recovery
        mc_hi = 0;
        repeat (450) @(posedge clk_sys);
        rd(`ETP_ADDR_STAT);
        chk1("clock lost", 1'b1, rd_v[7]);
        mc_hi = 100;
        repeat (450) @(posedge clk_sys);
        rd(`ETP_ADDR_STAT);
        chk1("still lost", 1'b1, rd_v[7]);
        chk1("no early reset", 1'b0, self_cnt != 0);
        mc_hi = 200;
        for (k = 0; k < 1000 && self_cnt == 0; k++) @(posedge clk_sys);
        chk1("auto reset", 1'b1, self_cnt == 1);
        repeat (3) @(posedge clk_sys);
        rd(`ETP_ADDR_MODE);
        chk8("mode after auto reset", 8'h00, rd_v);
        rd(`ETP_ADDR_ISTS);
        chk8("loss events", 8'h03, rd_v);
        wrap_up();
    end
endmodule : testbench
